// >>> rtl/pbwsc_params.svh
// timing counts and wake source indices for the power-button wake controller
`ifndef PBWSC_PARAMS_SVH
`define PBWSC_PARAMS_SVH
`define PBWSC_CLK_HZ 40000000
`define PBWSC_SHORT_S 4
`define PBWSC_LONG_S 6
`define PBWSC_SHORT_CYC (`PBWSC_SHORT_S * `PBWSC_CLK_HZ)
`define PBWSC_LONG_CYC (`PBWSC_LONG_S * `PBWSC_CLK_HZ)
`define PBWSC_CNT_W 28
`define PBWSC_NSRC 7
`define PBWSC_SRC_LAN 0
`define PBWSC_SRC_PME 1
`define PBWSC_SRC_SW 2
`define PBWSC_SRC_RTC 3
`define PBWSC_SRC_USB 4
`define PBWSC_SRC_PEW 5
`define PBWSC_SRC_CIR 6
`endif

// >>> rtl/pbwsc_pkg.sv
// types for the power-button wake controller
package pbwsc_pkg;
  typedef enum logic [2:0] {
    PBWSC_S0 = 3'h0,
    PBWSC_S1 = 3'h1,
    PBWSC_S3 = 3'h3,
    PBWSC_S4 = 3'h4,
    PBWSC_S5 = 3'h5
  } pbwsc_state_t;
  typedef enum logic [1:0] {
    PBWSC_HOLD_NONE = 2'h0,
    PBWSC_HOLD_SHORT = 2'h1,
    PBWSC_HOLD_LONG = 2'h2
  } pbwsc_hold_t;
endpackage : pbwsc_pkg

// >>> rtl/pbwsc_hold_timer.sv
// measures how long the power switch is held
`timescale 1ns/10ps
`default_nettype none
`include "pbwsc_params.svh"
module pbwsc_hold_timer
  import pbwsc_pkg::*;
#(
  parameter logic [27:0] SHORT_CYC = 28'(`PBWSC_SHORT_CYC),
  parameter logic [27:0] LONG_CYC = 28'(`PBWSC_LONG_CYC)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pressed,
  output logic done,
  output pbwsc_hold_t kind,
  output logic long_now
);
  logic [`PBWSC_CNT_W-1:0] count;
  logic was_pressed;
  logic long_fired;
  // saturate so a stuck switch cannot wrap back into the short window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= '0;
    end else if (pressed) begin
      if (count != LONG_CYC) count <= count + 28'h000_0001;
    end else begin
      count <= '0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) was_pressed <= 1'b0;
    else was_pressed <= pressed;
  end
  // long hold acts while still held, once per press
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      long_fired <= 1'b0;
      long_now <= 1'b0;
    end else begin
      long_now <= pressed && !long_fired && (count == LONG_CYC - 28'h000_0001);
      if (!pressed) long_fired <= 1'b0;
      else if (count == LONG_CYC - 28'h000_0001) long_fired <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done <= 1'b0;
      kind <= PBWSC_HOLD_NONE;
    end else begin
      done <= was_pressed && !pressed;
      if (count < SHORT_CYC) kind <= PBWSC_HOLD_SHORT;
      else if (count >= LONG_CYC) kind <= PBWSC_HOLD_LONG;
      else kind <= PBWSC_HOLD_NONE;
    end
  end
endmodule : pbwsc_hold_timer
`default_nettype wire

// >>> rtl/pbwsc_top.sv
// power-state controller driven by power switch holds and wake events
// Overview of operation
// - soft-off, short press powers on
// - working, short press enters sleep
// - working, six second hold forces soft-off
// - sleeping, short press wakes to working
// - sleeping, six second hold goes soft-off
// - switch, RTC, express wake everywhere; USB S1/S3
// - LAN, PME in S5 only when enabled
// - S5 option on enables LAN wake
// - infrared wakes S1/S3, S4/S5 optional
// - S3 wake resumes memory context, warm
// - wake from S5 is a cold boot
`timescale 1ns/10ps
`default_nettype none
`include "pbwsc_params.svh"
module pbwsc_top
  import pbwsc_pkg::*;
#(
  parameter logic [27:0] SHORT_CYC = 28'(`PBWSC_SHORT_CYC),
  parameter logic [27:0] LONG_CYC = 28'(`PBWSC_LONG_CYC),
  parameter bit CIR_DEEP_WAKE = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pwr_sw_n,
  input wire logic [6:0] wake_in,
  input wire logic s5_wake_en,
  input wire logic os_req,
  input wire logic [2:0] os_target,
  output pbwsc_state_t sys_state,
  output logic power_good_req,
  output logic ctx_retained,
  output logic cold_boot,
  output logic resume_warm
);
  logic sw_meta, sw_sync;
  logic [6:0] wake_meta, wake_sync, wake_prev;
  logic hold_done, long_now;
  pbwsc_hold_t hold_kind;
  logic [6:0] allowed, wake_edge;
  logic any_wake;
  pbwsc_state_t next_state;
  logic s5_en_meta, s5_en_sync;
  logic [27:0] chk_held;

  // two flops on the switch, wake and option pins before use; os_req and os_target are used directly
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
    end else begin
      sw_meta <= ~pwr_sw_n;
      sw_sync <= sw_meta;
    end
  end

  // prev flop makes the edge detector; resets low to match idle pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_meta <= 7'h00;
      wake_sync <= 7'h00;
      wake_prev <= 7'h00;
    end else begin
      wake_meta <= wake_in;
      wake_sync <= wake_meta;
      wake_prev <= wake_sync;
    end
  end

  // strap is slow but still a pin, so it gets the same two flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s5_en_meta <= 1'b0;
      s5_en_sync <= 1'b0;
    end else begin
      s5_en_meta <= s5_wake_en;
      s5_en_sync <= s5_en_meta;
    end
  end

  a_sw_two_flops: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> sw_sync == !$past(pwr_sw_n, 2))
    else $error("switch synchroniser delay wrong");
  a_wake_two_flops: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> wake_sync == $past(wake_in, 2))
    else $error("wake synchroniser delay wrong");
  a_opt_two_flops: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) |-> s5_en_sync == $past(s5_wake_en, 2))
    else $error("option synchroniser delay wrong");

  pbwsc_hold_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_hold (
    .ref_clk(ref_clk),
    .rst(rst),
    .pressed(sw_sync),
    .done(hold_done),
    .kind(hold_kind),
    .long_now(long_now)
  );

  // reference hold counter, so the timer is checked against an independent count
  always_ff @(posedge ref_clk) begin
    if (rst) chk_held <= 28'h000_0000;
    else if (!sw_sync) chk_held <= 28'h000_0000;
    else if (chk_held != LONG_CYC) chk_held <= chk_held + 28'h000_0001;
  end

  a_long_timing: assert property (@(posedge ref_clk) disable iff (rst)
    long_now |-> chk_held == LONG_CYC)
    else $error("long hold fired at the wrong count");
  a_long_first: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(chk_held == LONG_CYC) |-> long_now)
    else $error("long hold did not fire at its count");
  a_kind_short: assert property (@(posedge ref_clk) disable iff (rst)
    hold_done |-> (hold_kind == PBWSC_HOLD_SHORT) == ($past(chk_held) < SHORT_CYC))
    else $error("short hold class wrong");
  a_kind_long: assert property (@(posedge ref_clk) disable iff (rst)
    hold_done |-> (hold_kind == PBWSC_HOLD_LONG) == ($past(chk_held) >= LONG_CYC))
    else $error("long hold class wrong");

  // per source: which sleep states accept it
  genvar g;
  generate
    for (g = 0; g < `PBWSC_NSRC; g++) begin : g_src
      always_comb begin
        allowed[g] = 1'b0;
        case (sys_state)
          PBWSC_S1, PBWSC_S3: allowed[g] = 1'b1;
          PBWSC_S4: begin
            if (g == `PBWSC_SRC_USB) allowed[g] = 1'b0;
            else if (g == `PBWSC_SRC_CIR) allowed[g] = CIR_DEEP_WAKE;
            else allowed[g] = 1'b1;
          end
          PBWSC_S5: begin
            if (g == `PBWSC_SRC_USB) allowed[g] = 1'b0;
            else if (g == `PBWSC_SRC_CIR) allowed[g] = CIR_DEEP_WAKE;
            else if (g == `PBWSC_SRC_LAN || g == `PBWSC_SRC_PME) begin
              allowed[g] = s5_en_sync;
            end else allowed[g] = 1'b1;
          end
          default: allowed[g] = 1'b0;
        endcase
        wake_edge[g] = wake_sync[g] & ~wake_prev[g] & allowed[g];
      end
    end
  endgenerate
  assign any_wake = |wake_edge;

  // priority: forced off, then switch release, then wake, then os request
  always_comb begin
    next_state = sys_state;
    if (long_now && sys_state != PBWSC_S5) begin
      next_state = PBWSC_S5;
    end else if (hold_done && hold_kind == PBWSC_HOLD_SHORT) begin
      case (sys_state)
        PBWSC_S5: next_state = PBWSC_S0;
        PBWSC_S0: next_state = PBWSC_S3;
        PBWSC_S1, PBWSC_S3, PBWSC_S4: next_state = PBWSC_S0;
        default: next_state = sys_state;
      endcase
    end else if (any_wake) begin
      next_state = PBWSC_S0;
    end else if (os_req) begin
      case (os_target)
        3'h0: next_state = PBWSC_S0;
        3'h1: next_state = PBWSC_S1;
        3'h3: next_state = PBWSC_S3;
        3'h4: next_state = PBWSC_S4;
        3'h5: next_state = PBWSC_S5;
        default: next_state = sys_state;
      endcase
    end
  end

  // soft-off after reset: no context to resume
  always_ff @(posedge ref_clk) begin
    if (rst) sys_state <= PBWSC_S5;
    else sys_state <= next_state;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) power_good_req <= 1'b0;
    else power_good_req <= (next_state == PBWSC_S0) || (next_state == PBWSC_S1);
  end

  // memory keeps context in S1/S3; S4 keeps it on disk
  always_ff @(posedge ref_clk) begin
    if (rst) ctx_retained <= 1'b0;
    else ctx_retained <= (next_state == PBWSC_S1) || (next_state == PBWSC_S3);
  end

  // one-cycle pulses announcing the kind of boot on entry to S0 from S5 or S1/S3
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cold_boot <= 1'b0;
      resume_warm <= 1'b0;
    end else begin
      cold_boot <= next_state == PBWSC_S0 && sys_state == PBWSC_S5;
      resume_warm <= next_state == PBWSC_S0 &&
        (sys_state == PBWSC_S1 || sys_state == PBWSC_S3);
    end
  end

  a_long_forces_off: assert property (@(posedge ref_clk) disable iff (rst)
    long_now && sys_state != PBWSC_S5 |=> sys_state == PBWSC_S5)
    else $error("long hold did not force soft-off");
  a_short_on: assert property (@(posedge ref_clk) disable iff (rst)
    hold_done && hold_kind == PBWSC_HOLD_SHORT && !long_now && sys_state == PBWSC_S5
    |=> sys_state == PBWSC_S0 && cold_boot)
    else $error("short press from soft-off did not power on cold");
  a_short_sleep: assert property (@(posedge ref_clk) disable iff (rst)
    hold_done && hold_kind == PBWSC_HOLD_SHORT && !long_now && sys_state == PBWSC_S0
    |=> sys_state == PBWSC_S3)
    else $error("short press in working did not sleep");
  a_short_wake: assert property (@(posedge ref_clk) disable iff (rst)
    hold_done && hold_kind == PBWSC_HOLD_SHORT && !long_now &&
    (sys_state == PBWSC_S1 || sys_state == PBWSC_S3) |=> sys_state == PBWSC_S0 && resume_warm)
    else $error("short press did not wake");
  a_mid_hold_idle: assert property (@(posedge ref_clk) disable iff (rst)
    hold_done && hold_kind == PBWSC_HOLD_NONE && !long_now && !any_wake && !os_req
    |=> $stable(sys_state))
    else $error("mid-length hold changed state");
  a_usb_deep: assert property (@(posedge ref_clk) disable iff (rst)
    (sys_state == PBWSC_S4 || sys_state == PBWSC_S5) |-> !wake_edge[`PBWSC_SRC_USB])
    else $error("usb accepted in deep sleep");
  a_lan_s5_gate: assert property (@(posedge ref_clk) disable iff (rst)
    sys_state == PBWSC_S5 && !s5_en_sync |-> !wake_edge[`PBWSC_SRC_LAN] &&
    !wake_edge[`PBWSC_SRC_PME])
    else $error("lan or pme woke from S5 while disabled");
  a_lan_s5_on: assert property (@(posedge ref_clk) disable iff (rst)
    sys_state == PBWSC_S5 && s5_en_sync && wake_sync[`PBWSC_SRC_LAN] &&
    !wake_prev[`PBWSC_SRC_LAN] && !long_now && !hold_done |=> sys_state == PBWSC_S0)
    else $error("enabled lan wake from S5 ignored");
  a_cir_deep: assert property (@(posedge ref_clk) disable iff (rst)
    sys_state == PBWSC_S4 && !CIR_DEEP_WAKE |-> !wake_edge[`PBWSC_SRC_CIR])
    else $error("infrared woke from S4 while unsupported");
  a_ctx_hold: assert property (@(posedge ref_clk) disable iff (rst)
    sys_state == PBWSC_S3 ##1 sys_state == PBWSC_S3 |-> ctx_retained)
    else $error("context dropped in S3");
  a_cold_from_off: assert property (@(posedge ref_clk) disable iff (rst)
    cold_boot |-> $past(sys_state) == PBWSC_S5 && sys_state == PBWSC_S0 && !resume_warm)
    else $error("cold boot pulse without S5 exit");
  a_reset_soft_off: assert property (@(posedge ref_clk) rst |=>
    sys_state == PBWSC_S5 && !power_good_req && !ctx_retained && !cold_boot && !resume_warm)
    else $error("reset did not leave soft-off with outputs low");
  a_pg_level: assert property (@(posedge ref_clk) disable iff (rst)
    power_good_req == (sys_state == PBWSC_S0 || sys_state == PBWSC_S1))
    else $error("power request does not follow working states");
  a_ctx_deep_off: assert property (@(posedge ref_clk) disable iff (rst)
    sys_state == PBWSC_S4 || sys_state == PBWSC_S5 |-> !ctx_retained)
    else $error("memory context claimed in deep states");
  a_warm_src: assert property (@(posedge ref_clk) disable iff (rst)
    resume_warm |-> ($past(sys_state) == PBWSC_S1 || $past(sys_state) == PBWSC_S3) &&
    sys_state == PBWSC_S0 && !cold_boot)
    else $error("warm resume pulse without sleep exit");
  a_short_deep: assert property (@(posedge ref_clk) disable iff (rst)
    hold_done && hold_kind == PBWSC_HOLD_SHORT && !long_now && sys_state == PBWSC_S4
    |=> sys_state == PBWSC_S0 && !resume_warm && !cold_boot)
    else $error("short press did not wake from S4");
  a_long_release_idle: assert property (@(posedge ref_clk) disable iff (rst)
    hold_done && hold_kind == PBWSC_HOLD_LONG && !long_now && !any_wake && !os_req
    |=> $stable(sys_state))
    else $error("release after long hold changed state");
  a_wake_to_on: assert property (@(posedge ref_clk) disable iff (rst)
    any_wake && !long_now && !(hold_done && hold_kind == PBWSC_HOLD_SHORT)
    |=> sys_state == PBWSC_S0)
    else $error("accepted wake did not reach working");
  a_awake_no_wake: assert property (@(posedge ref_clk) disable iff (rst)
    sys_state == PBWSC_S0 |-> !any_wake)
    else $error("wake accepted while working");
  a_os_move: assert property (@(posedge ref_clk) disable iff (rst)
    os_req && !long_now && !hold_done && !any_wake &&
    os_target inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h5} |=> sys_state == $past(os_target))
    else $error("os request not carried out");
  a_os_bad_code: assert property (@(posedge ref_clk) disable iff (rst)
    os_req && !long_now && !hold_done && !any_wake &&
    !(os_target inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h5}) |=> $stable(sys_state))
    else $error("undefined os target changed state");
  a_state_legal: assert property (@(posedge ref_clk) disable iff (rst)
    sys_state inside {PBWSC_S0, PBWSC_S1, PBWSC_S3, PBWSC_S4, PBWSC_S5})
    else $error("state register holds an unused code");
  a_long_once: assert property (@(posedge ref_clk) disable iff (rst)
    long_now |=> !long_now)
    else $error("long hold fired twice in a row");
  a_cold_once: assert property (@(posedge ref_clk) disable iff (rst)
    cold_boot |=> !cold_boot)
    else $error("cold boot pulse longer than one cycle");

  c_long_off: cover property (@(posedge ref_clk) disable iff (rst)
    long_now && sys_state == PBWSC_S0);
  c_lan_wake: cover property (@(posedge ref_clk) disable iff (rst)
    wake_edge[`PBWSC_SRC_LAN] && sys_state == PBWSC_S5);
  c_warm: cover property (@(posedge ref_clk) disable iff (rst) resume_warm);
  c_os_sleep: cover property (@(posedge ref_clk) disable iff (rst)
    os_req && os_target == 3'h3);
  c_mid_hold: cover property (@(posedge ref_clk) disable iff (rst)
    hold_done && hold_kind == PBWSC_HOLD_NONE);
endmodule : pbwsc_top
`default_nettype wire

// >>> verification/pbwsc_partner.sv
// model of the power switch, wake sources and operating system
`timescale 1ns/10ps
`default_nettype none
module pbwsc_partner (
  input wire logic ref_clk,
  output logic pwr_sw_n,
  output logic [6:0] wake_in,
  output logic os_req,
  output logic [2:0] os_target
);
  initial begin
    pwr_sw_n = 1'b1;
    wake_in = 7'h00;
    os_req = 1'b0;
    os_target = 3'h0;
  end
  // released switch sits high on its pull-up
  task automatic press(input int n);
    @(posedge ref_clk) pwr_sw_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    pwr_sw_n <= 1'b1;
  endtask : press
  // held a few cycles so the synchroniser cannot miss the edge
  task automatic wake(input int i);
    @(posedge ref_clk) wake_in[i] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wake_in[i] <= 1'b0;
  endtask : wake
  // one-cycle request; target inverted afterwards, which still leaves a valid code after targets 3 and 4
  task automatic os(input logic [2:0] t);
    @(posedge ref_clk) begin
      os_req <= 1'b1;
      os_target <= t;
    end
    @(posedge ref_clk) begin
      os_req <= 1'b0;
      os_target <= ~t;
    end
  endtask : os
endmodule : pbwsc_partner
`default_nettype wire

// >>> verification/pbwsc_top_tb.sv
// self-checking bench for the power-button wake controller
`timescale 1ns/10ps
`default_nettype none
`include "pbwsc_params.svh"
module pbwsc_top_tb import pbwsc_pkg::*; ;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic s5_wake_en = 1'b0;
  logic pwr_sw_n;
  logic [6:0] wake_in;
  logic os_req;
  logic [2:0] os_target;
  pbwsc_state_t sys_state;
  logic power_good_req, ctx_retained, cold_boot, resume_warm;
  int n_fail = 0;
  int num_checks = 0;
  int n_cold = 0;
  int n_warm = 0;
  localparam int SHORT_T = 40;
  localparam int LONG_T = 60;
  always #12.5 ref_clk = ~ref_clk;
  pbwsc_partner sw (.ref_clk(ref_clk), .pwr_sw_n(pwr_sw_n), .wake_in(wake_in),
    .os_req(os_req), .os_target(os_target));
  // short counts keep the run small: 40 and 60 cycles
  pbwsc_top #(.SHORT_CYC(28'(SHORT_T)), .LONG_CYC(28'(LONG_T))) dut (.ref_clk(ref_clk),
    .rst(rst), .pwr_sw_n(pwr_sw_n), .wake_in(wake_in), .s5_wake_en(s5_wake_en),
    .os_req(os_req), .os_target(os_target), .sys_state(sys_state),
    .power_good_req(power_good_req), .ctx_retained(ctx_retained),
    .cold_boot(cold_boot), .resume_warm(resume_warm));
  // pulses are one cycle wide, so count them as they pass
  always @(posedge ref_clk) begin
    if (cold_boot === 1'b1) n_cold <= n_cold + 1;
    if (resume_warm === 1'b1) n_warm <= n_warm + 1;
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_n
  task automatic t_reset;
    check(sys_state, PBWSC_S5);
    check({power_good_req, ctx_retained, cold_boot, resume_warm}, 4'h0);
  endtask : t_reset
  task automatic t_cycle;
    int c;
    int w;
    c = n_cold;
    sw.press(SHORT_T / 4);
    wait_n(8);
    check(sys_state, PBWSC_S0);
    check(power_good_req, 1'b1);
    check(4'(n_cold - c), 4'h1);
    sw.press(SHORT_T / 4);
    wait_n(8);
    check(sys_state, PBWSC_S3);
    check(power_good_req, 1'b0);
    check(ctx_retained, 1'b1);
    w = n_warm;
    sw.press(SHORT_T / 4);
    wait_n(8);
    check(sys_state, PBWSC_S0);
    check(4'(n_warm - w), 4'h1);
  endtask : t_cycle
  task automatic t_holds;
    logic [2:0] bad;
    bad = 3'h2;
    sw.press(SHORT_T + 10);
    wait_n(8);
    check(sys_state, PBWSC_S0);
    sw.press(LONG_T + 10);
    wait_n(8);
    check(sys_state, PBWSC_S5);
    sw.os(PBWSC_S1);
    wait_n(2);
    check(sys_state, PBWSC_S1);
    sw.os(bad);
    wait_n(2);
    check(sys_state, PBWSC_S1);
    sw.press(LONG_T + 10);
    wait_n(8);
    check(sys_state, PBWSC_S5);
    sw.os(PBWSC_S0);
    wait_n(2);
    check(sys_state, PBWSC_S0);
  endtask : t_holds
  // infrared deep wake is off in this build
  function automatic bit may_wake(int s, logic [2:0] st, bit en);
    if (s == `PBWSC_SRC_USB || s == `PBWSC_SRC_CIR) return st == 3'h1 || st == 3'h3;
    if (s == `PBWSC_SRC_LAN || s == `PBWSC_SRC_PME) return st != 3'h5 || en;
    return 1'b1;
  endfunction : may_wake
  task automatic t_wake;
    logic [2:0] sts [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h5};
    for (int s = 0; s < `PBWSC_NSRC; s++) begin
      for (int k = 0; k < 5; k++) begin
        @(posedge ref_clk) s5_wake_en <= (k == 4);
        sw.os(sts[k]);
        wait_n(2);
        sw.wake(s);
        wait_n(6);
        check(sys_state, may_wake(s, sts[k], k == 4) ? 3'h0 : sts[k]);
      end
    end
  endtask : t_wake
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    wait_n(2);
    t_reset();
    t_cycle();
    t_holds();
    t_wake();
    summarize();
  end
  // whole run needs about 860 cycles
  initial begin
    #(25 * 30000);
    n_fail++;
    summarize();
  end
endmodule : pbwsc_top_tb
`default_nettype wire
